// >>> hw/cmfc_top.sv
// can mode control, abort, time stamp and filter group 7 with wishbone regs
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cmfc_top (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // wishbone classic slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // message engine side
   input  wire logic [31:0]             tx_pending_i,
   input  wire logic                    eng_busy_i,
   input  wire logic                    rx_valid_i,
   input  wire logic [15:0]             flt_match_i,
   output logic      [31:0]             tx_abort_o,
   output logic                         module_en_o,
   output logic      [2:0]              op_mode_o,
   output logic                         tx_allowed_o,
   output logic      [15:0]             rx_stamp_o,
   output logic                         rx_stamp_vld_o,
   output logic                         rx_accept_o,
   output logic      [4:0]              rx_fifo_o
);

   // ---------------- wishbone slave ----------------
   logic        ack_r;
   logic [31:0] rdat_r;
   logic [31:0] rd_val;
   logic        req_go;
   logic        wr_go;
   logic        hit_ctrl;
   logic        hit_flt;

   assign req_go   = wb_cyc_i & wb_stb_i & ~ack_r;
   // writes take effect on the edge where the master sees ack
   assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   assign hit_ctrl = (wb_adr_i == cmfc_pkg::ADR_MODULE_CTRL);
   assign hit_flt  = (wb_adr_i == cmfc_pkg::ADR_FLT_GROUP7);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_go;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_r <= 32'h0000_0000;
      end else if (req_go) begin
         rdat_r <= rd_val;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ---------------- control register state ----------------
   logic        abort_r;
   logic [2:0]  req_r;
   logic [2:0]  cur_r;
   logic        cap_r;
   logic        on_r;
   logic        sidle_r;
   logic        active_r;
   logic [4:0]  dncnt_r;
   logic        tx_ok_r;
   logic        wr_b3;
   logic        wr_b2;
   logic        wr_b1;
   logic        wr_b0;
   logic        abort_set;
   logic        abort_done;

   assign wr_b3 = wr_go & hit_ctrl & wb_sel_i[3];
   assign wr_b2 = wr_go & hit_ctrl & wb_sel_i[2];
   assign wr_b1 = wr_go & hit_ctrl & wb_sel_i[1];
   assign wr_b0 = wr_go & hit_ctrl & wb_sel_i[0];

   assign abort_set  = wr_b3 & wb_dat_i[cmfc_pkg::ABORT_BIT];
   assign abort_done = abort_r & (tx_pending_i == 32'h0000_0000);

   // a set in the same cycle as the hardware clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         abort_r <= 1'b0;
      end else if (abort_set) begin
         abort_r <= 1'b1;
      end else if (abort_done) begin
         abort_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_abort_o <= 32'h0000_0000;
      end else begin
         tx_abort_o <= {cmfc_pkg::NUM_TXBUF{abort_r & ~abort_done}};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_r <= cmfc_pkg::REQ_RST;
      end else if (wr_b3 && cmfc_pkg::mode_is_legal(
                  wb_dat_i[cmfc_pkg::REQ_LSB +: 3])) begin
         req_r <= wb_dat_i[cmfc_pkg::REQ_LSB +: 3];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_r   <= 1'b0;
         on_r    <= 1'b0;
         sidle_r <= 1'b0;
         dncnt_r <= cmfc_pkg::DNCNT_RST;
      end else begin
         if (wr_b2) cap_r <= wb_dat_i[cmfc_pkg::CAP_BIT];
         if (wr_b1) begin
            on_r    <= wb_dat_i[cmfc_pkg::ON_BIT];
            sidle_r <= wb_dat_i[cmfc_pkg::SIDLE_BIT];
         end
         if (wr_b0) dncnt_r <= wb_dat_i[cmfc_pkg::DNCNT_LSB +: 5];
      end
   end

   // module stays active until the engine finishes its transaction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
      end else begin
         active_r <= on_r | (active_r & eng_busy_i);
      end
   end

   assign module_en_o = active_r;

   // ---------------- mode change sequencer ----------------
   cmfc_pkg::cmfc_state_t st_r;
   logic [3:0]            settle_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r     <= cmfc_pkg::ST_IDLE;
         settle_r <= 4'h0;
         cur_r    <= cmfc_pkg::OPM_RST;
         tx_ok_r  <= 1'b0;
      end else begin
         case (st_r)
            cmfc_pkg::ST_IDLE: begin
               if (req_r != cur_r) st_r <= cmfc_pkg::ST_DRAIN;
            end
            cmfc_pkg::ST_DRAIN: begin
               if (!eng_busy_i) begin
                  st_r     <= cmfc_pkg::ST_SETTLE;
                  settle_r <= cmfc_pkg::SETTLE_LD;
               end
            end
            cmfc_pkg::ST_SETTLE: begin
               if (settle_r == 4'h0) begin
                  cur_r   <= req_r;
                  tx_ok_r <= cmfc_pkg::mode_may_tx(req_r);
                  st_r    <= cmfc_pkg::ST_IDLE;
               end else begin
                  settle_r <= settle_r - 4'h1;
               end
            end
            default: st_r <= cmfc_pkg::ST_IDLE;
         endcase
      end
   end

   assign op_mode_o    = cur_r;
   assign tx_allowed_o = tx_ok_r;

   // ---------------- receive time stamp ----------------
   logic [15:0] tmr_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmr_r <= 16'h0000;
      end else if (cap_r) begin
         tmr_r <= tmr_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_stamp_o     <= 16'h0000;
         rx_stamp_vld_o <= 1'b0;
      end else begin
         rx_stamp_vld_o <= rx_valid_i & cap_r;
         if (rx_valid_i && cap_r) rx_stamp_o <= tmr_r;
      end
   end

   // ---------------- filters 28 to 31 ----------------
   cmfc_pkg::cmfc_flt_t cfg [cmfc_pkg::NUM_FLT];
   logic [3:0]          flt_hit;
   logic                wr_flt;

   assign wr_flt = wr_go & hit_flt;

   genvar g;
   generate
      for (g = 0; g < cmfc_pkg::NUM_FLT; g++) begin : g_flt
         cmfc_flt_slot u_slot (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .wr_i    (wr_flt & wb_sel_i[g]),
            .wdat_i  (cmfc_pkg::cmfc_flt_t'(wb_dat_i[8*g +: 8])),
            .match_i (flt_match_i[4*g +: 4]),
            .cfg_o   (cfg[g]),
            .hit_o   (flt_hit[g])
         );
      end
   endgenerate

   // lowest numbered enabled filter that matches picks the fifo
   logic [4:0] fifo_sel;

   always_comb begin
      fifo_sel = 5'h00;
      for (int i = cmfc_pkg::NUM_FLT - 1; i >= 0; i--) begin
         if (flt_hit[i]) fifo_sel = cfg[i].fsel;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_accept_o <= 1'b0;
         rx_fifo_o   <= 5'h00;
      end else begin
         rx_accept_o <= rx_valid_i & active_r & (|flt_hit);
         if (rx_valid_i && (|flt_hit)) rx_fifo_o <= fifo_sel;
      end
   end

   // ---------------- read mux ----------------
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_val = {4'h0, abort_r, req_r, cur_r, cap_r, 4'h0,
                   on_r, 1'b0, sidle_r, 1'b0, active_r, 3'h0,
                   3'h0, dncnt_r};
      end else if (hit_flt) begin
         rd_val = {cfg[3], cfg[2], cfg[1], cfg[0]};
      end
   end

   // ---------------- checks ----------------
   localparam int SET_HI = cmfc_pkg::SETTLE_CYC + 1;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_settle_start;
      st_r == cmfc_pkg::ST_DRAIN && !eng_busy_i;
   endsequence

   sequence s_mode_done;
      st_r == cmfc_pkg::ST_IDLE && cur_r == $past(req_r);
   endsequence

   a_abort_clear: assert property (
      abort_done && !abort_set |=> !abort_r)
      else $error("abort flag not cleared after all aborted");

   a_abort_hold: assert property (
      abort_r && (tx_pending_i != 32'h0000_0000) |=> abort_r &&
      (tx_abort_o == 32'hFFFF_FFFF))
      else $error("abort dropped while transmissions pending");

   a_req_legal: assert property (
      cmfc_pkg::mode_is_legal(req_r))
      else $error("reserved mode code held in request");

   a_mode_seq: assert property (
      s_settle_start |-> ##SET_HI s_mode_done)
      else $error("mode status not updated after settle");

   a_mode_cause: assert property (
      cur_r != $past(cur_r) |-> $past(st_r) == cmfc_pkg::ST_SETTLE)
      else $error("mode status changed outside settle");

   a_stamp_latch: assert property (
      rx_valid_i && cap_r |=> rx_stamp_vld_o && rx_stamp_o == $past(tmr_r))
      else $error("time stamp not latched on reception");

   a_timer_stop: assert property (
      !cap_r |=> $stable(tmr_r))
      else $error("time stamp timer ran while capture off");

   a_off_wait: assert property (
      active_r && !on_r && eng_busy_i |=> module_en_o)
      else $error("module turned off mid transaction");

   a_off_done: assert property (
      !on_r && !eng_busy_i |=> !module_en_o)
      else $error("module still enabled after idle");

   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule : cmfc_top

// >>> hw/cmfc_pkg.sv
// shared constants and types for the can mode and filter control block
package cmfc_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [7:0] ADR_MODULE_CTRL = 8'h00;
   localparam logic [7:0] ADR_FLT_GROUP7  = 8'h04;

   // field positions in can_module_control
   localparam int ABORT_BIT  = 27;
   localparam int REQ_LSB    = 24;
   localparam int OPM_LSB    = 21;
   localparam int CAP_BIT    = 20;
   localparam int ON_BIT     = 15;
   localparam int SIDLE_BIT  = 13;
   localparam int BUSY_BIT   = 11;
   localparam int DNCNT_LSB  = 0;

   // widths
   localparam int NUM_TXBUF  = 32;
   localparam int NUM_FLT    = 4;
   localparam int NUM_MASK   = 4;
   localparam int TMR_W      = 16;

   // operating mode codes, shared by request and status fields
   typedef enum logic [2:0] {
      MODE_NORMAL     = 3'h0,
      MODE_DISABLE    = 3'h1,
      MODE_LOOPBACK   = 3'h2,
      MODE_LISTEN     = 3'h3,
      MODE_CONFIG     = 3'h4,
      MODE_RSVD5      = 3'h5,
      MODE_RSVD6      = 3'h6,
      MODE_LISTEN_ALL = 3'h7
   } cmfc_mode_t;

   // values after reset
   localparam cmfc_mode_t REQ_RST   = MODE_CONFIG;
   localparam cmfc_mode_t OPM_RST   = MODE_CONFIG;
   localparam logic [4:0] DNCNT_RST = 5'h00;

   // mode change settle time after the engine goes idle
   localparam int CLK_NS        = 10;
   localparam int MODE_SETTLE_NS = 30;
   localparam int SETTLE_CYC    = (MODE_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] SETTLE_LD = 4'(SETTLE_CYC - 1);

   // mode change sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_DRAIN  = 3'b010,
      ST_SETTLE = 3'b100
   } cmfc_state_t;

   // one filter byte: enable on top, mask select, fifo select at bottom
   typedef struct packed {
      logic       en;
      logic [1:0] msel;
      logic [4:0] fsel;
   } cmfc_flt_t;

   localparam cmfc_flt_t FLT_RST = 8'h00;

   function automatic logic mode_is_legal(input logic [2:0] m);
      return (m != MODE_RSVD5) && (m != MODE_RSVD6);
   endfunction : mode_is_legal

   function automatic logic mode_may_tx(input logic [2:0] m);
      return (m == MODE_NORMAL) || (m == MODE_LOOPBACK);
   endfunction : mode_may_tx

endpackage : cmfc_pkg

// >>> hw/cmfc_flt_slot.sv
// one acceptance filter slot: config byte, write lock and match gating
`timescale 1ns/1ps
module cmfc_flt_slot (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wr_i,
   input  wire cmfc_pkg::cmfc_flt_t wdat_i,
   input  wire logic [3:0]         match_i,
   output cmfc_pkg::cmfc_flt_t     cfg_o,
   output logic                    hit_o
);

   cmfc_pkg::cmfc_flt_t cfg_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= cmfc_pkg::FLT_RST;
      end else if (wr_i) begin
         cfg_r.en <= wdat_i.en;
         if (!cfg_r.en) begin
            cfg_r.msel <= wdat_i.msel;
            cfg_r.fsel <= wdat_i.fsel;
         end
      end
   end

   // a disabled filter never matches; msel picks one of four mask results
   assign hit_o = cfg_r.en & match_i[cfg_r.msel];
   assign cfg_o = cfg_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_cfg_locked: assert property (
      $past(cfg_r.en) |-> $stable(cfg_r.msel) && $stable(cfg_r.fsel))
      else $error("filter config changed while enabled");

   a_cfg_accept: assert property (
      wr_i && !cfg_r.en |=> cfg_r.en == $past(wdat_i.en) &&
      cfg_r.msel == $past(wdat_i.msel) && cfg_r.fsel == $past(wdat_i.fsel))
      else $error("filter config write lost while disabled");

   a_hit_gated: assert property (
      hit_o |-> cfg_r.en && match_i[cfg_r.msel])
      else $error("filter hit without enable or selected mask");

endmodule : cmfc_flt_slot

// >>> verification/cmfc_eng_model.sv
// partner model: message engine and bus-side traffic around the control block
`timescale 1ns/1ps
module cmfc_eng_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] tx_abort_i,
   input  wire logic        busy_hold_i,
   input  wire logic        rx_go_i,
   input  wire logic [15:0] match_i,
   output logic      [31:0] tx_pending_o,
   output logic             eng_busy_o,
   output logic             rx_valid_o,
   output logic      [15:0] flt_match_o
);
   // buffers give up their frames a few at a time, not all at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pending_o <= 32'hFFFF_FFFF;
      end else if (|tx_abort_i) begin
         tx_pending_o <= tx_pending_o >> 8;
      end
   end

   // a transaction lasts as long as the bench holds it
   assign eng_busy_o = busy_hold_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_valid_o  <= 1'b0;
         flt_match_o <= 16'h0000;
      end else begin
         rx_valid_o  <= rx_go_i;
         // match lines mean nothing away from a valid pulse
         flt_match_o <= rx_go_i ? match_i : ~flt_match_o;
      end
   end
endmodule : cmfc_eng_model

// >>> verification/tb_top.sv
// self-checking bench for the can mode and filter control block
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] CTL = cmfc_pkg::ADR_MODULE_CTRL;
   localparam logic [7:0] FLT = cmfc_pkg::ADR_FLT_GROUP7;
   logic        clk_i  = 1'b0;
   logic        rst_i  = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we  = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_dw  = 32'h0000_0000;
   logic [3:0]  wb_sel = 4'hF;
   logic [3:0]  lanes  = 4'hF;
   logic [15:0] match  = 16'h0000;
   logic        busy_hold = 1'b0;
   logic        rx_go  = 1'b0;
   logic [31:0] wb_dr, tx_pend, tx_abort, q;
   logic [15:0] fmatch, rx_stamp, got_s, s1;
   logic        eng_busy, rx_valid, ack, men, txa, svld, acc, got_v, got_a;
   logic [2:0]  opm;
   logic [4:0]  fifo, got_f;
   int          miscompares = 0;
   int          checks = 0;

   always #5 clk_i = ~clk_i;

   cmfc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(ack),
      .tx_pending_i(tx_pend), .eng_busy_i(eng_busy), .rx_valid_i(rx_valid),
      .flt_match_i(fmatch), .tx_abort_o(tx_abort), .module_en_o(men),
      .op_mode_o(opm), .tx_allowed_o(txa), .rx_stamp_o(rx_stamp),
      .rx_stamp_vld_o(svld), .rx_accept_o(acc), .rx_fifo_o(fifo));

   cmfc_eng_model eng (.clk_i(clk_i), .rst_i(rst_i), .tx_abort_i(tx_abort),
      .busy_hold_i(busy_hold), .rx_go_i(rx_go), .match_i(match),
      .tx_pending_o(tx_pend), .eng_busy_o(eng_busy),
      .rx_valid_o(rx_valid), .flt_match_o(fmatch));

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one classic cycle; q holds read data
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_sel <= lanes;
      wb_dw  <= d;
      // ack and read data are taken at the rising edge that samples ack
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) miscompares++;
      q = wb_dr;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // one reception, four cycles long
   task automatic rx(input logic [15:0] m);
      got_v = 1'b0;
      got_a = 1'b0;
      match <= m;
      rx_go <= 1'b1;
      @(posedge clk_i);
      rx_go <= 1'b0;
      repeat (3) begin
         @(negedge clk_i);
         if (svld === 1'b1) begin
            got_v = 1'b1;
            got_s = rx_stamp;
         end
         if (acc === 1'b1) begin
            got_a = 1'b1;
            got_f = fifo;
         end
      end
      @(posedge clk_i);
   endtask : rx

   task automatic t_mode();
      logic [2:0] c [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
      logic [2:0] prev;
      prev = 3'h4;
      foreach (c[i]) begin
         busy_hold <= 1'b1;
         wb(1'b1, CTL, 32'(c[i]) << 24);
         repeat (5) @(posedge clk_i);
         wb(1'b0, CTL, 32'h0);
         chk(q[23:21], prev, "status held");
         busy_hold <= 1'b0;
         for (int n = 0; n < 20 && opm !== c[i]; n++) @(posedge clk_i);
         chk(opm, c[i], "op_mode");
         chk(txa, c[i] == 3'h0 || c[i] == 3'h2, "tx_allowed");
         wb(1'b0, CTL, 32'h0);
         chk(q[23:21], c[i], "status");
         prev = c[i];
      end
      wb(1'b1, CTL, 32'h0500_0000);
      wb(1'b0, CTL, 32'h0);
      chk(q[26:21], 6'h24, "reserved request");
   endtask : t_mode

   task automatic t_abort();
      wb(1'b1, CTL, 32'h0C00_0000);
      @(posedge clk_i);
      chk(tx_abort, 32'hFFFF_FFFF, "tx_abort set");
      for (int n = 0; n < 20 && tx_abort !== 0; n++) @(posedge clk_i);
      chk(tx_abort | tx_pend, 32'h0, "tx_abort clear");
      wb(1'b0, CTL, 32'h0);
      chk(q[27], 1'b0, "abort bit");
   endtask : t_abort

   task automatic t_onoff();
      busy_hold <= 1'b1;
      wb(1'b1, CTL, 32'h0400_8000);
      @(posedge clk_i);
      chk(men, 1'b1, "module on");
      wb(1'b1, CTL, 32'h0400_0000);
      repeat (3) @(posedge clk_i);
      wb(1'b0, CTL, 32'h0);
      chk({q[15], q[11], men}, 3'h3, "busy finishing");
      busy_hold <= 1'b0;
      for (int n = 0; n < 10 && men !== 1'b0; n++) @(posedge clk_i);
      wb(1'b0, CTL, 32'h0);
      chk({q[11], men}, 2'h0, "module off");
      wb(1'b1, CTL, 32'h0410_8000);
   endtask : t_onoff

   task automatic t_stamp();
      rx(16'h0000);
      s1 = got_s;
      chk(got_v, 1'b1, "stamp valid");
      rx(16'h0000);
      chk(16'(got_s - s1), 16'h0004, "stamp spacing");
      wb(1'b1, CTL, 32'h0400_8000);
      rx(16'h0000);
      chk(got_v, 1'b0, "capture off");
   endtask : t_stamp

   task automatic t_flt();
      logic [15:0] mt [6] = '{16'h0004, 16'h0002, 16'h0020, 16'h0800,
                              16'h1000, 16'h1020};
      logic        ea [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      logic [4:0]  ef [6] = '{5'h15, 5'h00, 5'h0A, 5'h00, 5'h03, 5'h0A};
      wb(1'b1, FLT, 32'h837F_AAD5);
      wb(1'b0, FLT, 32'h0);
      chk(q, 32'h837F_AAD5, "filter word");
      foreach (mt[i]) begin
         rx(mt[i]);
         chk(got_a, ea[i], "accept");
         if (ea[i]) chk(got_f, ef[i], "fifo");
      end
      wb(1'b1, FLT, 32'h0);
      wb(1'b0, FLT, 32'h0);
      chk(q, 32'h0300_2A55, "locked config");
      rx(16'h0004);
      chk(got_a, 1'b0, "disabled filter");
      // lanes 0 and 2 only: filters 28 and 30, both disabled now
      lanes = 4'h5;
      wb(1'b1, FLT, 32'h00C5_00B1);
      lanes = 4'hF;
      wb(1'b0, FLT, 32'h0);
      chk(q, 32'h03C5_2AB1, "byte lanes");
      rx(16'h0402);
      chk(got_a, 1'b1, "reconfigured accept");
      chk(got_f, 5'h11, "reconfigured fifo");
   endtask : t_flt

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CTL, 32'h0);
      chk(q, 32'h0480_0000, "ctrl reset");
      wb(1'b0, FLT, 32'h0);
      chk(q, 32'h0, "filter reset");
      wb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0, "unmapped");
      t_mode();
      t_abort();
      t_onoff();
      t_stamp();
      t_flt();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end
endmodule : tb_top
